// [mcu_reset_defines.svh]
// constants of the microcontroller reset sequencer
`ifndef MCU_RESET_DEFINES_SVH
`define MCU_RESET_DEFINES_SVH

`define RST_DELAY_CYCLES    2048
`define PC_WIDTH            12
`define RST_VECTOR          12'hFFE
`define PORT_DIR_ADDR       8'hC4
`define PORT_DIR_RESET      8'h00
`define ARTIMER_CTRL3_ADDR  8'hE2
`define ARTIMER_CTRL3_RESET 8'h00
`define WDOG_REG_RESET      8'hFE
// synchroniser start {osc, por, pin}: power-on asserted, pin released,
// so hold comes from power-on alone and no false pin cause is logged
`define PIN_SYNC_RESET      3'h3

`endif

// [mcu_reset_pkg.sv]
// types shared by the reset sequencer
`include "mcu_reset_defines.svh"
package mcu_reset_pkg;

  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_WAIT,
    MODE_STOP
  } power_mode_t;

  typedef enum logic [2:0] {
    SEQ_HOLD,
    SEQ_DELAY,
    SEQ_INIT,
    SEQ_NMI,
    SEQ_RUN
  } seq_state_t;

  typedef struct packed {
    logic pin;
    logic por;
    logic wdog;
  } reset_cause_t;

  typedef struct packed {
    logic       load;
    logic [7:0] port_dir;
    logic [7:0] artimer_ctrl3;
    logic [7:0] wdog_reg;
  } periph_init_t;

  typedef struct packed {
    logic                  stack_clear;
    logic                  pc_load;
    logic [`PC_WIDTH-1:0]  pc_value;
    logic                  nmi_mode;
  } core_init_t;

endpackage : mcu_reset_pkg

// [reset_pin_sync.sv]
// two-flop synchroniser for asynchronous reset-related inputs
module reset_pin_sync #(
  parameter int               WIDTH   = 3,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clk_i,
  input  wire logic             rstn_i,
  input  wire logic             clk_en_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  always_comb begin
    meta_d = async_i;
    sync_d = meta_q;
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else if (clk_en_i) begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_o = sync_q;

endmodule : reset_pin_sync

// [mcu_reset_sequencer.sv]
// reset source merge, stabilisation delay and core start-up sequencing
`include "mcu_reset_defines.svh"
module mcu_reset_sequencer #(
  parameter int DELAY_CYCLES = `RST_DELAY_CYCLES
) (
  input  wire logic                       clk_i,
  input  wire logic                       rstn_i,
  input  wire logic                       clk_en_i,
  input  wire logic                       ext_reset_n_i,
  input  wire logic                       por_detect_i,
  input  wire logic                       osc_running_i,
  input  wire logic                       aux_osc_tick_i,
  input  wire logic                       wdog_expired_i,
  input  wire mcu_reset_pkg::power_mode_t power_mode_i,
  input  wire logic                       return_from_interrupt_i,
  input  wire logic                       irq_pending_i,
  input  wire logic                       osc_off_set_i,
  input  wire logic                       osc_off_clr_i,
  output logic                            core_reset_o,
  output logic                            halt_exec_o,
  output logic                            io_pullup_input_o,
  output logic                            osc_restart_o,
  output logic                            main_osc_turn_off_o,
  output mcu_reset_pkg::core_init_t       core_init_o,
  output mcu_reset_pkg::periph_init_t     periph_init_o,
  output logic                            service_irq_o,
  output logic                            resume_next_o,
  output mcu_reset_pkg::reset_cause_t     reset_cause_o,
  output mcu_reset_pkg::power_mode_t      reset_mode_o
);

  localparam int CW = (DELAY_CYCLES > 2) ? $clog2(DELAY_CYCLES) : 1;
  localparam logic [CW-1:0] CNT_LAST = CW'(DELAY_CYCLES - 1);

  // short local names for the state codes, package kept unimported
  localparam mcu_reset_pkg::seq_state_t SEQ_HOLD  = mcu_reset_pkg::SEQ_HOLD;
  localparam mcu_reset_pkg::seq_state_t SEQ_DELAY = mcu_reset_pkg::SEQ_DELAY;
  localparam mcu_reset_pkg::seq_state_t SEQ_INIT  = mcu_reset_pkg::SEQ_INIT;
  localparam mcu_reset_pkg::seq_state_t SEQ_NMI   = mcu_reset_pkg::SEQ_NMI;
  localparam mcu_reset_pkg::seq_state_t SEQ_RUN   = mcu_reset_pkg::SEQ_RUN;

  if (DELAY_CYCLES < 2 || DELAY_CYCLES > 65536) begin : g_bad_delay
    $error("DELAY_CYCLES out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisation

  logic [2:0] pins_s;
  logic       pin_n_s;
  logic       por_s;
  logic       osc_run_s;

  // pin and detector cross in from outside; power-on reads asserted at start
  reset_pin_sync #(
    .WIDTH   (3),
    .RST_VAL (`PIN_SYNC_RESET)
  ) u_sync (
    .clk_i    (clk_i),
    .rstn_i   (rstn_i),
    .clk_en_i (clk_en_i),
    .async_i  ({osc_running_i, por_detect_i, ext_reset_n_i}),
    .sync_o   (pins_s)
  );

  assign pin_n_s   = pins_s[0];
  assign por_s     = pins_s[1];
  assign osc_run_s = pins_s[2];

  ////////////////////////////////////////////////////////////////////////////
  // sequencing state

  mcu_reset_pkg::seq_state_t   state_q;
  mcu_reset_pkg::seq_state_t   state_d;
  logic [CW-1:0]               cnt_q;
  logic [CW-1:0]               cnt_d;
  mcu_reset_pkg::reset_cause_t cause_q;
  mcu_reset_pkg::reset_cause_t cause_d;
  mcu_reset_pkg::reset_cause_t cause_now;
  mcu_reset_pkg::power_mode_t  mode_q;
  mcu_reset_pkg::power_mode_t  mode_d;
  logic                        any_src;
  logic                        tick;

  always_comb begin
    cause_now.pin  = !pin_n_s;
    cause_now.por  = por_s;
    cause_now.wdog = wdog_expired_i;
    any_src = cause_now.pin | cause_now.por | cause_now.wdog;
    // aux oscillator paces the delay until the main one is up
    tick    = osc_run_s | aux_osc_tick_i;
    state_d = state_q;
    cnt_d   = cnt_q;
    cause_d = cause_q;
    mode_d  = mode_q;
    unique case (state_q)
      SEQ_HOLD: begin
        cnt_d = '0;
        if (!any_src) begin
          state_d = SEQ_DELAY;
        end
      end
      SEQ_DELAY: begin
        if (tick) begin
          if (cnt_q == CNT_LAST) begin
            state_d = SEQ_INIT;
          end else begin
            cnt_d = cnt_q + CW'(1);
          end
        end
      end
      SEQ_INIT: begin
        state_d = SEQ_NMI;
      end
      SEQ_NMI: begin
        if (return_from_interrupt_i) begin
          state_d = SEQ_RUN;
        end
      end
      SEQ_RUN: begin
      end
    endcase
    // any source, in any power mode, wins over the sequence
    if (any_src) begin
      state_d = SEQ_HOLD;
      cnt_d   = '0;
      if (state_q != SEQ_HOLD) begin
        cause_d = cause_now;
        mode_d  = power_mode_i;
      end else begin
        cause_d = cause_q | cause_now;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q <= mcu_reset_pkg::SEQ_HOLD;
      cnt_q   <= '0;
      cause_q <= '{pin: 1'b0, por: 1'b1, wdog: 1'b0};
      mode_q  <= mcu_reset_pkg::MODE_RUN;
    end else if (clk_en_i) begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      cause_q <= cause_d;
      mode_q  <= mode_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs

  logic                         in_reset_d;
  logic                         core_reset_q;
  logic                         osc_restart_q;
  logic                         osc_restart_d;
  logic                         osc_off_q;
  logic                         osc_off_d;
  logic                         service_q;
  logic                         service_d;
  logic                         resume_q;
  logic                         resume_d;
  mcu_reset_pkg::core_init_t    core_q;
  mcu_reset_pkg::core_init_t    core_d;
  mcu_reset_pkg::periph_init_t  periph_q;
  mcu_reset_pkg::periph_init_t  periph_d;

  always_comb begin
    // outputs follow the next state so they line up with it
    in_reset_d    = (state_d == SEQ_HOLD) || (state_d == SEQ_DELAY);
    // one pulse per entry: restart in run/wait, start in stop
    osc_restart_d = any_src && (state_q != SEQ_HOLD);
    if (in_reset_d) begin
      osc_off_d = 1'b0;
    end else if (osc_off_set_i) begin
      osc_off_d = 1'b1;
    end else if (osc_off_clr_i) begin
      osc_off_d = 1'b0;
    end else begin
      osc_off_d = osc_off_q;
    end
    core_d.stack_clear = (state_d == SEQ_INIT);
    core_d.pc_load     = (state_d == SEQ_INIT);
    core_d.pc_value    = `RST_VECTOR;
    // reset wins over the ending return in the same cycle
    core_d.nmi_mode    = in_reset_d || (state_d == SEQ_INIT)
                         || (state_d == SEQ_NMI);
    service_d = (state_q == SEQ_NMI) && (state_d == SEQ_RUN)
                && irq_pending_i;
    resume_d  = (state_q == SEQ_NMI) && (state_d == SEQ_RUN)
                && !irq_pending_i;
    // peripherals are held at their reset values all through reset
    periph_d.load          = in_reset_d || (state_d == SEQ_INIT);
    periph_d.port_dir      = `PORT_DIR_RESET;
    periph_d.artimer_ctrl3 = `ARTIMER_CTRL3_RESET;
    periph_d.wdog_reg      = `WDOG_REG_RESET;
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      core_reset_q  <= 1'b1;
      osc_restart_q <= 1'b1;
      osc_off_q     <= 1'b0;
      service_q     <= 1'b0;
      resume_q      <= 1'b0;
      core_q        <= '{stack_clear: 1'b0, pc_load: 1'b0,
                         pc_value: `RST_VECTOR, nmi_mode: 1'b1};
      periph_q      <= '{load: 1'b1, port_dir: `PORT_DIR_RESET,
                         artimer_ctrl3: `ARTIMER_CTRL3_RESET,
                         wdog_reg: `WDOG_REG_RESET};
    end else if (clk_en_i) begin
      core_reset_q  <= in_reset_d;
      osc_restart_q <= osc_restart_d;
      osc_off_q     <= osc_off_d;
      service_q     <= service_d;
      resume_q      <= resume_d;
      core_q        <= core_d;
      periph_q      <= periph_d;
    end
  end

  // halt and pull-ups share the reset flop: one level, no skew between them
  assign core_reset_o        = core_reset_q;
  assign halt_exec_o         = core_reset_q;
  assign io_pullup_input_o   = core_reset_q;
  assign osc_restart_o       = osc_restart_q;
  assign main_osc_turn_off_o = osc_off_q;
  assign core_init_o         = core_q;
  assign periph_init_o       = periph_q;
  assign service_irq_o       = service_q;
  assign resume_next_o       = resume_q;
  assign reset_cause_o       = cause_q;
  assign reset_mode_o        = mode_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_i iff clk_en_i);
  endclocking
  default disable iff (!rstn_i);

  sequence s_last_tick;
    (state_q == SEQ_DELAY) && tick && (cnt_q == CNT_LAST) && !any_src;
  endsequence

  sequence s_init_out;
    !core_reset_o && core_init_o.pc_load && core_init_o.stack_clear;
  endsequence

  sequence s_end_init;
    (state_q == SEQ_NMI) && return_from_interrupt_i && !any_src;
  endsequence

  a_pin_holds_reset: assert property (
    !pin_n_s |=> core_reset_o && io_pullup_input_o && halt_exec_o)
    else $error("pin low but core left reset");

  a_wdog_reset: assert property (
    wdog_expired_i |=> core_reset_o
      && (periph_init_o.wdog_reg == 8'hFE) && periph_init_o.load)
    else $error("watchdog expiry did not reset");

  a_delay_release: assert property (
    s_last_tick |=> s_init_out)
    else $error("reset not released at end of delay");

  a_delay_full: assert property (
    $fell(core_reset_o) |-> $past(cnt_q) == CNT_LAST)
    else $error("reset released before delay ran out");

  a_delay_restart: assert property (
    any_src |=> (cnt_q == '0) ##1 (cnt_q == '0))
    else $error("delay counter not restarted by a source");

  a_idle_no_count: assert property (
    (state_q == SEQ_DELAY) && !tick && !any_src |=> $stable(cnt_q))
    else $error("delay counted without a clock tick");

  a_vector_load: assert property (
    core_init_o.pc_load |-> core_init_o.pc_value == 12'hFFE
      && core_init_o.nmi_mode)
    else $error("wrong reset vector or mode at load");

  a_nmi_until_rfi: assert property (
    core_init_o.pc_load && !any_src && !return_from_interrupt_i
      |=> core_init_o.nmi_mode && !core_reset_o)
    else $error("non-maskable mode dropped early");

  a_rfi_service: assert property (
    s_end_init |=> (service_irq_o == $past(irq_pending_i))
      && (resume_next_o == !$past(irq_pending_i)) && !core_init_o.nmi_mode)
    else $error("wrong action on ending return");

  a_osc_on_reset: assert property (
    any_src && (state_q != SEQ_HOLD)
      |=> osc_restart_o && !main_osc_turn_off_o)
    else $error("oscillator not restarted by reset");

  a_periph_values: assert property (
    core_reset_o |-> periph_init_o.load && periph_init_o.port_dir == 8'h00
      && periph_init_o.artimer_ctrl3 == 8'h00)
    else $error("peripheral reset values not applied");

endmodule : mcu_reset_sequencer

// [reset_board_model.sv]
// board supervisor model driving the active-low reset pin
module reset_board_model (
  input  wire logic       clk_i,
  input  wire logic       start_i,
  input  wire logic [5:0] len_i,
  output logic            ext_reset_n_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [5:0] cnt_q;
  initial cnt_q = 6'h00;
  // pin pulled low for len_i cycles in any power mode
  always @(negedge clk_i) begin
    if (start_i) begin
      cnt_q <= len_i;
    end else if (cnt_q != 6'h00) begin
      cnt_q <= cnt_q - 6'h01;
    end
  end
  // released pin sits at the built-in pull-up level
  assign ext_reset_n_o = (cnt_q == 6'h00);
endmodule : reset_board_model

// [test_mcu_reset_sequencer.sv]
// self-checking bench for the reset sequencer
module test_mcu_reset_sequencer;
  timeunit 1ns;
  timeprecision 100ps;
  // short delay keeps the run small; bounds derive from it
  localparam int DLY = 8;
  logic clk, rstn, por, osc, aux, wdog, rfi, irq, oset, start, pin_n;
  logic rst, halt, pull, orst, moff, srv, res;
  logic [5:0]                   len;
  mcu_reset_pkg::power_mode_t   mode, rmode;
  mcu_reset_pkg::core_init_t    core;
  mcu_reset_pkg::periph_init_t  per;
  mcu_reset_pkg::reset_cause_t  cause;
  int                           fails, num_checks;
  //////////////////////////////////////////////////////////////////////
  reset_board_model i_board (.clk_i(clk), .start_i(start), .len_i(len),
    .ext_reset_n_o(pin_n));
  mcu_reset_sequencer #(.DELAY_CYCLES(DLY)) i_dut (
    .clk_i(clk), .rstn_i(rstn), .clk_en_i(1'b1),
    .ext_reset_n_i(pin_n), .por_detect_i(por), .osc_running_i(osc),
    .aux_osc_tick_i(aux), .wdog_expired_i(wdog), .power_mode_i(mode),
    .return_from_interrupt_i(rfi), .irq_pending_i(irq),
    .osc_off_set_i(oset), .osc_off_clr_i(1'b0), .core_reset_o(rst),
    .halt_exec_o(halt), .io_pullup_input_o(pull), .osc_restart_o(orst),
    .main_osc_turn_off_o(moff), .core_init_o(core), .periph_init_o(per),
    .service_irq_o(srv), .resume_next_o(res), .reset_cause_o(cause),
    .reset_mode_o(rmode));
  //////////////////////////////////////////////////////////////////////
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  task automatic timeout(string what);
    fails++;
    $display("BAD %s exp done got timeout", what);
    tally_and_finish;
  endtask : timeout
  task automatic wait_rise;
    int n;
    n = 0;
    while (rst !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 8) timeout("rise");
    end
  endtask : wait_rise
  // div > 0: while osc is low, delay advances only on aux ticks every div cycles
  task automatic wait_fall(int lo, int hi, int div);
    int n;
    n = 0;
    while (rst !== 1'b0) begin
      aux <= (div != 0) && (n % div == 0);
      @(negedge clk);
      n++;
      if (n > hi) timeout("fall");
    end
    aux <= 1'b0;
    chk("delay_min", 1, n >= lo);
    chk("pc_load", 1, core.pc_load);
    chk("stack_clear", 1, core.stack_clear);
    chk("pc_value", 12'hFFE, core.pc_value);
    @(negedge clk);
    chk("pc_load_end", 0, core.pc_load);
    chk("nmi_mode", 1, core.nmi_mode);
  endtask : wait_fall
  task automatic end_init(logic p);
    int n;
    irq <= p;
    rfi <= 1'b1;
    @(negedge clk);
    rfi <= 1'b0;
    n = 0;
    while ((srv | res) !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 3) timeout("return");
    end
    chk("service_irq", p, srv);
    chk("resume_next", !p, res);
    chk("nmi_after", 0, core.nmi_mode);
    @(negedge clk);
    irq <= 1'b0;
  endtask : end_init
  //////////////////////////////////////////////////////////////////////
  task automatic t_power_on;
    repeat (6) @(negedge clk);
    chk("por_hold", 1, rst);
    chk("por_halt", 1, halt);
    chk("por_pull", 1, pull);
    chk("por_cause", 3'h2, cause);
    chk("per_load", 1, per.load);
    chk("port_dir", 8'h00, per.port_dir);
    chk("artimer", 8'h00, per.artimer_ctrl3);
    chk("wdog_reg", 8'hFE, per.wdog_reg);
    chk("osc_off", 0, moff);
    por <= 1'b0;
    wait_fall(4 * DLY, 4 * DLY + 16, 4);
    end_init(1'b0);
    osc <= 1'b1;
    repeat (4) @(negedge clk);
  endtask : t_power_on
  task automatic t_pin(mcu_reset_pkg::power_mode_t m, int l, logic p);
    int n;
    mode <= m;
    len <= 6'(l);
    start <= 1'b1;
    @(negedge clk);
    start <= 1'b0;
    wait_rise;
    chk("osc_restart", 1, orst);
    chk("reset_mode", m, rmode);
    chk("pin_cause", 3'h4, cause);
    chk("pin_pull", 1, pull);
    chk("pin_halt", 1, halt);
    n = 0;
    while (pin_n !== 1'b1) begin
      chk("pin_held", 1, rst);
      @(negedge clk);
      n++;
      if (n > 70) timeout("pin");
    end
    wait_fall(DLY + 1, DLY + 6, 0);
    end_init(p);
  endtask : t_pin
  task automatic t_wdog;
    oset <= 1'b1;
    @(negedge clk);
    oset <= 1'b0;
    @(negedge clk);
    chk("osc_off_set", 1, moff);
    wdog <= 1'b1;
    @(negedge clk);
    wdog <= 1'b0;
    wait_rise;
    chk("wd_osc_off", 0, moff);
    chk("wd_cause", 3'h1, cause);
    chk("wd_load", 1, per.load);
    chk("wd_reg", 8'hFE, per.wdog_reg);
    chk("wd_restart", 1, orst);
    wait_fall(DLY, DLY + 4, 0);
    end_init(1'b0);
  endtask : t_wdog
  //////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    rstn = 1'b0;
    por = 1'b1;
    osc = 1'b0;
    aux = 1'b0;
    wdog = 1'b0;
    rfi = 1'b0;
    irq = 1'b0;
    oset = 1'b0;
    start = 1'b0;
    len = 6'h00;
    mode = mcu_reset_pkg::MODE_RUN;
    fails = 0;
    num_checks = 0;
    repeat (12) @(negedge clk);
    rstn <= 1'b1;
    t_power_on;
    t_pin(mcu_reset_pkg::MODE_RUN, 2, 1'b1);
    t_pin(mcu_reset_pkg::MODE_WAIT, 20, 1'b0);
    t_pin(mcu_reset_pkg::MODE_STOP, 20, 1'b1);
    t_wdog;
    tally_and_finish;
  end
endmodule : test_mcu_reset_sequencer
